// >>> src/uart_ctl_pkg.sv
// Package with register map, field positions and mode codes of the UART.
`default_nettype none
package uart_ctl_pkg;
  // Byte addresses of the word registers on the bus.
  localparam logic [7:0] ADDR_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_DATA    = 8'h99;
  localparam logic [7:0] ADDR_STATUS  = 8'ha0;
  localparam logic [7:0] ADDR_AUX     = 8'ha4;
  localparam logic [7:0] ADDR_POWER   = 8'ha8;
  localparam logic [7:0] ADDR_BAUD    = 8'hac;
  // Control register field positions.
  localparam int CTL_RX_DONE = 0;
  localparam int CTL_TX_DONE = 1;
  localparam int CTL_RB8     = 2;
  localparam int CTL_TB8     = 3;
  localparam int CTL_REN     = 4;
  localparam int CTL_MPF     = 5;
  localparam int CTL_MLO     = 6;
  localparam int CTL_MHI     = 7;
  // Status register field positions.
  localparam int ST_FE    = 3;
  localparam int ST_BRK   = 2;
  localparam int ST_TX_IRQ_POSITION_SEL = 6;
  // Aux and power field positions.
  localparam int AUX_BRR    = 6;
  localparam int PWR_FESEL  = 6;
  localparam int PWR_SMOD1  = 7;
  // Reset values and timing constants.
  localparam logic [7:0]  CTL_RESET   = 8'h00;
  localparam logic [15:0] BAUD_RESET  = 16'h000f;
  localparam logic [3:0]  BREAK_BITS  = 4'hb;
  localparam logic [3:0]  OVERSAMPLE  = 4'hf;
  localparam logic [3:0]  MID_SAMPLE  = 4'h7;
  localparam logic [4:0]  DIV_MODE0   = 5'h0f;
  localparam logic [4:0]  DIV_FAST    = 5'h0f;
  localparam logic [4:0]  DIV_SLOW    = 5'h1f;
  // Serial port modes.
  typedef enum logic [1:0] {
    MODE_SHIFT, MODE_8BIT, MODE_9FIXED, MODE_9VAR
  } uart_mode_t;
  // Bus request bundle.
  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
  } bus_req_t;
endpackage : uart_ctl_pkg
`default_nettype wire

// >>> src/bit_tick_gen.sv
// Bit-rate tick generator: one-cycle tick every div+1 clocks.
`default_nettype none
module bit_tick_gen (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Control.
  input  wire logic        sync_i,
  input  wire logic [15:0] div_i,
  // Tick out.
  output logic             tick_o
);
  logic [15:0] cnt;

  // Count down, reload on sync or expiry.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 16'h0000;
    end else if (sync_i || cnt == 16'h0000) begin
      cnt <= div_i;
    end else begin
      cnt <= cnt - 16'h0001;
    end
  end

  assign tick_o = !sync_i && (cnt == 16'h0000);
endmodule : bit_tick_gen
`default_nettype wire

// >>> src/uart_control_break_detect.sv
// UART control register, framing, break detect and serial engine.
//
// Added by the designer: the AHB-Lite slave port.
`default_nettype none
module uart_control_break_detect
  import uart_ctl_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // AHB-Lite slave.
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Serial pins; receive pin is two-way in mode 0.
  input  wire logic        rxd_i,
  output logic             rxd_o,
  output logic             rxd_oe_o,
  output logic             txd_o,
  // Break-triggered reset request.
  output logic             break_reset_o,
  output logic             in_system_prog_mode_o
);
  import uart_ctl_pkg::*;

  typedef enum {R_IDLE, R_RUN, R_BREAK} rx_state_t;
  typedef enum {T_IDLE, T_RUN} tx_state_t;

  // Registers.
  logic [7:0]  serial_port_control;
  logic        frame_error;
  logic        break_flag;
  logic        tx_irq_position_sel;
  logic        break_reset_en;
  logic        frame_err_view_sel;
  logic        smod1;
  logic [15:0] baud_div;
  logic [7:0]  uart_data_buffer;
  bus_req_t    req;
  rx_state_t   rx_state;
  tx_state_t   tx_state;
  logic [3:0]  rx_phase;
  logic [3:0]  rx_bit;
  logic [8:0]  rx_shift;
  logic [3:0]  tx_phase;
  logic [3:0]  tx_bit;
  logic [10:0] tx_shift;
  logic [3:0]  brk_cnt;
  logic        mclk;
  logic        tick;
  logic [15:0] tick_div;
  logic        tx_start;
  logic        hw_rx_done;
  logic        hw_tx_done;
  logic        hw_fe;
  logic        hw_brk;
  logic        rx_sample;
  logic [3:0]  rx_last;
  logic [3:0]  tx_last;
  uart_mode_t  mode;
  logic        wr_ctl;
  logic [7:0]  wd;

  assign mode = uart_mode_t'(serial_port_control[CTL_MHI:CTL_MLO]);
  assign wd   = hwdata_i[7:0];
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // Latch the address phase of a valid transfer.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req <= '0;
    end else if (hready_i) begin
      req.sel   <= hsel_i && htrans_i[1];
      req.write <= hwrite_i;
      req.addr  <= haddr_i[7:0];
    end
  end

  assign wr_ctl   = req.sel && req.write && req.addr == ADDR_CONTROL;
  assign tx_start = req.sel && req.write && req.addr == ADDR_DATA;

  // Read data multiplexer, driven from registers only.
  always_comb begin
    hrdata_o = 32'h0000_0000;
    if (req.sel && !req.write) begin
      case (req.addr)
        ADDR_CONTROL: begin
          hrdata_o[7:0] = serial_port_control;
          if (frame_err_view_sel) begin
            hrdata_o[CTL_MHI] = frame_error;
          end
        end
        ADDR_DATA: hrdata_o[7:0] = uart_data_buffer;
        ADDR_STATUS: begin
          hrdata_o[ST_FE]    = frame_error;
          hrdata_o[ST_BRK]   = break_flag;
          hrdata_o[ST_TX_IRQ_POSITION_SEL] = tx_irq_position_sel;
        end
        ADDR_AUX: hrdata_o[AUX_BRR] = break_reset_en;
        ADDR_POWER: begin
          hrdata_o[PWR_FESEL] = frame_err_view_sel;
          hrdata_o[PWR_SMOD1] = smod1;
        end
        ADDR_BAUD: hrdata_o[15:0] = baud_div;
        default: hrdata_o = 32'h0000_0000;
      endcase
    end
  end

  // Control register with hardware-set flags winning over writes.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      serial_port_control <= CTL_RESET;
    end else begin
      if (wr_ctl) begin
        serial_port_control[6:0] <= wd[6:0];
        if (!frame_err_view_sel) begin
          serial_port_control[CTL_MHI] <= wd[CTL_MHI];
        end
      end
      if (hw_rx_done) begin
        serial_port_control[CTL_RX_DONE] <= 1'b1;
        // The ninth bit is still on the pin when done fires at bit 9.
        serial_port_control[CTL_RB8] <= rx_bit == 4'h9 ? rxd_i
                                        : rx_shift[8];
      end
      if (hw_tx_done) begin
        serial_port_control[CTL_TX_DONE] <= 1'b1;
      end
    end
  end

  // Framing error and break flags; sticky until software writes.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frame_error <= 1'b0;
      break_flag  <= 1'b0;
    end else begin
      if (wr_ctl && frame_err_view_sel) begin
        frame_error <= wd[CTL_MHI];
      end else if (req.sel && req.write && req.addr == ADDR_STATUS) begin
        frame_error <= wd[ST_FE];
        break_flag  <= wd[ST_BRK];
      end
      if (hw_fe || hw_brk) begin
        frame_error <= 1'b1;
      end
      if (hw_brk) begin
        break_flag <= 1'b1;
      end
    end
  end

  // Auxiliary, power and rate configuration registers.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_irq_position_sel <= 1'b0;
      break_reset_en      <= 1'b0;
      frame_err_view_sel  <= 1'b0;
      smod1               <= 1'b0;
      baud_div            <= BAUD_RESET;
    end else if (req.sel && req.write) begin
      case (req.addr)
        ADDR_STATUS: tx_irq_position_sel <= wd[ST_TX_IRQ_POSITION_SEL];
        ADDR_AUX:    break_reset_en <= wd[AUX_BRR];
        ADDR_POWER: begin
          frame_err_view_sel <= wd[PWR_FESEL];
          smod1              <= wd[PWR_SMOD1];
        end
        ADDR_BAUD:   baud_div <= hwdata_i[15:0];
        default:     baud_div <= baud_div;
      endcase
    end
  end

  // Sixteenth-bit tick: fixed divide in modes 0 and 2.
  always_comb begin
    case (mode)
      MODE_SHIFT:  tick_div = 16'(DIV_MODE0 >> 4);
      MODE_9FIXED: tick_div = smod1 ? 16'h0000 : 16'h0001;
      default:     tick_div = baud_div;
    endcase
  end

  bit_tick_gen u_tick (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .sync_i (1'b0),
    .div_i  (tick_div),
    .tick_o (tick)
  );

  // Receive mid-bit sample point and last bit index per mode.
  assign rx_sample = tick && rx_phase == MID_SAMPLE;
  assign rx_last = mode == MODE_SHIFT ? 4'h7
                 : mode == MODE_8BIT ? 4'h9 : 4'ha;

  // Receiver state machine.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_state <= R_IDLE;
      rx_phase <= 4'h0;
      rx_bit   <= 4'h0;
      rx_shift <= 9'h000;
      uart_data_buffer <= 8'h00;
    end else begin
      if (tick) begin
        rx_phase <= rx_phase + 4'h1;
      end
      case (rx_state)
        R_IDLE: begin
          if (hw_brk) begin
            rx_state <= R_BREAK;
          end else if (serial_port_control[CTL_REN] && (mode == MODE_SHIFT
              ? !serial_port_control[CTL_RX_DONE] && tx_state == T_IDLE
              : !rxd_i)) begin
            rx_state <= R_RUN;
            rx_bit   <= 4'h0;
            rx_phase <= 4'h0;
          end
        end
        R_RUN: begin
          if (!serial_port_control[CTL_REN]) begin
            rx_state <= R_IDLE;
          end else if (hw_brk) begin
            rx_state <= R_BREAK;
          end else if (rx_sample) begin
            if (mode == MODE_SHIFT) begin
              rx_shift <= {1'b0, rxd_i, rx_shift[7:1]};
            end else if (rx_bit != 4'h0 && rx_bit <= 4'h8) begin
              rx_shift <= {1'b0, rxd_i, rx_shift[7:1]};
            end else if (rx_bit == 4'h9 && mode != MODE_8BIT) begin
              rx_shift[8] <= rxd_i;
            end
            if (rx_bit == 4'h0 && mode != MODE_SHIFT && rxd_i) begin
              rx_state <= R_IDLE;
            end else if (rx_bit == rx_last) begin
              rx_state <= R_IDLE;
              uart_data_buffer <= mode == MODE_SHIFT
                ? {rxd_i, rx_shift[7:1]} : rx_shift[7:0];
            end
            rx_bit <= rx_bit + 4'h1;
          end
        end
        R_BREAK: begin
          if (rxd_i) begin
            rx_state <= R_IDLE;
          end
        end
        default: rx_state <= R_IDLE;
      endcase
    end
  end

  // Receive-done timing per mode, with the multiprocessor filter.
  always_comb begin
    hw_rx_done = 1'b0;
    hw_fe      = 1'b0;
    if (rx_state == R_RUN && rx_sample && serial_port_control[CTL_REN]) begin
      case (mode)
        MODE_SHIFT: hw_rx_done = rx_bit == 4'h7;
        MODE_8BIT: begin
          hw_rx_done = rx_bit == 4'h9;
          hw_fe      = rx_bit == 4'h9 && !rxd_i;
        end
        default: begin
          hw_fe = rx_bit == 4'ha && !rxd_i;
          if (!(serial_port_control[CTL_MPF] &&
                !(rx_bit == 4'h9 ? rxd_i : rx_shift[8]))) begin
            hw_rx_done = frame_err_view_sel ? rx_bit == 4'ha
                                            : rx_bit == 4'h9;
          end
        end
      endcase
    end
  end

  // Break counter: low bit samples, carried over a frame end so that a
  // low run longer than one frame still counts; a high line clears it.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      brk_cnt <= 4'h0;
    end else if (mode == MODE_SHIFT || rx_state == R_BREAK
                 || !serial_port_control[CTL_REN]) begin
      brk_cnt <= 4'h0;
    end else if (rx_state == R_IDLE && rxd_i) begin
      brk_cnt <= 4'h0;
    end else if (rx_state == R_RUN && rx_sample) begin
      if (rxd_i) begin
        brk_cnt <= 4'h0;
      end else if (brk_cnt != BREAK_BITS) begin
        brk_cnt <= brk_cnt + 4'h1;
      end
    end
  end

  // Fires for one cycle only, as the receiver moves to the break state.
  assign hw_brk = mode != MODE_SHIFT && rx_state != R_BREAK
                  && brk_cnt == BREAK_BITS;

  // Break reset request into programming mode.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      break_reset_o         <= 1'b0;
      in_system_prog_mode_o <= 1'b0;
    end else begin
      break_reset_o <= hw_brk && break_reset_en;
      if (hw_brk && break_reset_en) begin
        in_system_prog_mode_o <= 1'b1;
      end
    end
  end

  // Transmitter: frame shift register and bit sequencing.
  assign tx_last = mode == MODE_SHIFT ? 4'h7
                 : mode == MODE_8BIT ? 4'h9 : 4'ha;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_state <= T_IDLE;
      tx_phase <= 4'h0;
      tx_bit   <= 4'h0;
      tx_shift <= 11'h7ff;
    end else begin
      case (tx_state)
        T_IDLE: begin
          if (tx_start) begin
            tx_state <= T_RUN;
            tx_phase <= 4'h0;
            tx_bit   <= 4'h0;
            if (mode == MODE_SHIFT) begin
              tx_shift <= {3'h7, wd};
            end else if (mode == MODE_8BIT) begin
              tx_shift <= {2'h3, wd, 1'b0};
            end else begin
              tx_shift <= {1'b1, serial_port_control[CTL_TB8], wd,
                           1'b0};
            end
          end
        end
        T_RUN: begin
          if (tick) begin
            tx_phase <= tx_phase + 4'h1;
            if (tx_phase == OVERSAMPLE) begin
              tx_shift <= {1'b1, tx_shift[10:1]};
              tx_bit   <= tx_bit + 4'h1;
              if (tx_bit == tx_last) begin
                tx_state <= T_IDLE;
              end
            end
          end
        end
        default: tx_state <= T_IDLE;
      endcase
    end
  end

  // Transmit-done: end of bit 7 in mode 0, stop bit start or end else.
  always_comb begin
    hw_tx_done = 1'b0;
    if (tx_state == T_RUN && tick) begin
      if (mode == MODE_SHIFT) begin
        hw_tx_done = tx_bit == 4'h7 && tx_phase == OVERSAMPLE;
      end else if (tx_irq_position_sel) begin
        hw_tx_done = tx_bit == tx_last && tx_phase == OVERSAMPLE;
      end else begin
        hw_tx_done = tx_bit == tx_last && tx_phase == 4'h0;
      end
    end
  end

  // Mode 0 shift clock, low in the first half of each bit of the engine
  // that runs; the free-running phase of an idle engine is ignored.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mclk <= 1'b1;
    end else begin
      mclk <= !((tx_state == T_RUN && !tx_phase[3])
                || (rx_state == R_RUN && !rx_phase[3]));
    end
  end

  // Pin drive: mode 0 puts data on the receive pin, clock on transmit.
  assign txd_o    = mode == MODE_SHIFT ? mclk : tx_shift[0];
  assign rxd_o    = tx_shift[0];
  assign rxd_oe_o = mode == MODE_SHIFT && tx_state == T_RUN;
endmodule : uart_control_break_detect
`default_nettype wire

// >>> testbench/uart_ctl_asserts.sv
// Checker for bus answer, break reset and idle levels at the top ports.
`default_nettype none
module uart_ctl_asserts (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic nrst_i,
  // Bus answer.
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // Serial pins and reset request.
  input wire logic rxd_i,
  input wire logic rxd_oe_o,
  input wire logic txd_o,
  input wire logic break_reset_o,
  input wire logic in_system_prog_mode_o
);
  // A break needs about ten bit times of low line at the fastest rate.
  localparam int LOW_MIN = 150;
  logic [7:0] low_run;

  // Counts clocks of an unbroken low run on the receive line.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_run <= 8'h00;
    end else if (rxd_i) begin
      low_run <= 8'h00;
    end else if (low_run != 8'hff) begin
      low_run <= low_run + 8'h01;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_ready_always: assert property (hreadyout_o)
    else $error("bus ready dropped");
  a_resp_okay: assert property (!hresp_o)
    else $error("bus error response");
  a_brk_pulse_one:
    assert property (break_reset_o |=> !break_reset_o)
    else $error("break reset pulse too long");
  a_brk_sets_isp:
    assert property (break_reset_o |=> in_system_prog_mode_o)
    else $error("programming mode not entered");
  a_isp_sticky:
    assert property (in_system_prog_mode_o |=> in_system_prog_mode_o)
    else $error("programming mode dropped");
  a_isp_cause:
    assert property ($rose(in_system_prog_mode_o) |->
                     break_reset_o || $past(break_reset_o))
    else $error("programming mode without break");
  a_brk_low_run:
    assert property (break_reset_o |-> low_run >= LOW_MIN)
    else $error("break without long low run");
  a_reset_idle:
    assert property ($rose(nrst_i) |-> txd_o && !rxd_oe_o)
    else $error("pins not idle after reset");
  a_reset_quiet:
    assert property ($rose(nrst_i) |->
                     (!break_reset_o && !in_system_prog_mode_o) [*3])
    else $error("reset request right after reset");

  c_break: cover property (break_reset_o);
  c_tx_start: cover property ($fell(txd_o));
  c_long_low: cover property (low_run == 8'hff);
  c_shift_out: cover property (rxd_oe_o);
endmodule : uart_ctl_asserts
`default_nettype wire

// >>> testbench/uart_node.sv
// Remote serial node: sends frames to the receiver, catches sent frames.
`default_nettype none
module uart_node (
  // Clock.
  input  wire logic clk_i,
  // Serial lines seen from the far end.
  input  wire logic txd_i,
  output logic      rxd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_CLK = 16;

  // The line idles high between frames.
  initial rxd_o = 1'b1;

  // Sends n bits, first bit first, then holds a valid stop level.
  task automatic send(input logic [23:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      rxd_o <= bits[i];
      repeat (BIT_CLK - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    rxd_o <= 1'b1;
    repeat (2 * BIT_CLK) @(posedge clk_i);
  endtask : send

  // Waits for a start edge and samples n bits at mid bit.
  task automatic grab(output logic [10:0] bits, input int n);
    int w;
    bits = 11'h7ff;
    w = 0;
    while (txd_i !== 1'b0 && w < 4000) begin
      @(posedge clk_i);
      w++;
    end
    repeat (BIT_CLK / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd_i;
      repeat (BIT_CLK) @(posedge clk_i);
    end
  endtask : grab
endmodule : uart_node
`default_nettype wire

// >>> testbench/tb_top.sv
// Top-level testbench: bus driver, serial scenarios and verdict.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import uart_ctl_pkg::*;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        dev_rxd;
  logic        dev_oe;
  logic        node_rxd;
  logic        rxd_line;
  logic        txd;
  logic        in_system_prog_mode;
  int          miscompares = 0;
  int          num_checks = 0;

  // Clock and the shared receive wire.
  always #2.5 clk_i = ~clk_i;
  assign rxd_line = dev_oe ? dev_rxd : node_rxd;

  uart_control_break_detect u_uart_control_break_detect (
    .clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(), .rxd_i(rxd_line),
    .rxd_o(dev_rxd), .rxd_oe_o(dev_oe), .txd_o(txd),
    .break_reset_o(), .in_system_prog_mode_o(in_system_prog_mode));
  uart_node u_uart_node (.clk_i(clk_i), .txd_i(txd), .rxd_o(node_rxd));

  // Compares one value and counts the outcome.
  task automatic check(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : check

  // One single-word bus transfer; read data is taken at the last edge.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    q = hrdata;
    hsel <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  // Reads a register and compares the masked value.
  task automatic rd(input string n, input logic [7:0] a,
                    input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    check(n, e, q & m);
  endtask : rd

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  // Cuts a hang short.
  initial begin
    repeat (40000) @(posedge clk_i);
    miscompares++;
    give_verdict();
  end

  // Main sequence of scenarios.
  initial begin
    logic [7:0]  d;
    logic [10:0] got;
    logic [1:0]  m;
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd("control", ADDR_CONTROL, 32'hff, 32'h0);
    rd("rate", ADDR_BAUD, 32'hffff, 32'h000f);
    rd("unmapped", 8'hb0, 32'hffffffff, 32'h0);
    wr(ADDR_POWER, 32'h80);
    wr(ADDR_BAUD, 32'h0);
    for (int i = 1; i < 4; i++) begin
      m = i[1:0];
      d = 8'h5a + {6'h0, m};
      wr(ADDR_CONTROL, {24'h0, m, 6'h10});
      if (m == 2'b01) u_uart_node.send({14'h0, 1'b1, d, 1'b0}, 10);
      else u_uart_node.send({13'h0, 1'b1, m[0], d, 1'b0}, 11);
      rd("rx ctl", ADDR_CONTROL, 32'hff,
         {24'h0, m, 3'b010, m[0], 2'b01});
      rd("rx data", ADDR_DATA, 32'hff, {24'h0, d});
    end
    wr(ADDR_CONTROL, 32'hb0);
    u_uart_node.send({13'h0, 2'b10, 8'h33, 1'b0}, 11);
    rd("filtered", ADDR_CONTROL, 32'hf3, 32'hb0);
    u_uart_node.send({13'h0, 2'b11, 8'h44, 1'b0}, 11);
    rd("addressed", ADDR_CONTROL, 32'hff, 32'hb5);
    wr(ADDR_CONTROL, 32'h80);
    u_uart_node.send({13'h0, 2'b11, 8'h55, 1'b0}, 11);
    rd("disabled", ADDR_CONTROL, 32'hff, 32'h80);
    wr(ADDR_CONTROL, 32'h90);
    u_uart_node.send({13'h0, 2'b00, 8'h81, 1'b0}, 11);
    rd("frame err", ADDR_STATUS, 32'h0c, 32'h08);
    u_uart_node.send({13'h0, 2'b11, 8'h18, 1'b0}, 11);
    rd("err sticky", ADDR_STATUS, 32'h08, 32'h08);
    wr(ADDR_POWER, 32'hc0);
    rd("err view", ADDR_CONTROL, 32'h80, 32'h80);
    wr(ADDR_CONTROL, 32'h10);
    rd("err clear", ADDR_STATUS, 32'h08, 32'h00);
    wr(ADDR_POWER, 32'h80);
    rd("mode kept", ADDR_CONTROL, 32'hf0, 32'h90);
    wr(ADDR_STATUS, 32'h0);
    u_uart_node.send(24'h0, 13);
    u_uart_node.send({13'h0, 2'b11, 8'h66, 1'b0}, 11);
    rd("break", ADDR_STATUS, 32'h0c, 32'h0c);
    rd("after break", ADDR_DATA, 32'hff, 32'h66);
    wr(ADDR_STATUS, 32'h0);
    u_uart_node.send(24'h000400, 21);
    rd("split low", ADDR_STATUS, 32'h0c, 32'h00);
    wr(ADDR_CONTROL, 32'h98);
    wr(ADDR_DATA, 32'h3c);
    u_uart_node.grab(got, 11);
    check("tx frame", {21'h0, 2'b11, 8'h3c, 1'b0}, {21'h0, got});
    rd("tx done", ADDR_CONTROL, 32'h02, 32'h02);
    wr(ADDR_AUX, 32'h40);
    u_uart_node.send(24'h0, 13);
    check("prog mode", 32'h1, {31'h0, in_system_prog_mode});
    // Mode 0 send: data leaves on the receive pin at a fixed clk/16 rate.
    wr(ADDR_CONTROL, 32'h00);
    wr(ADDR_DATA, 32'ha5);
    repeat (9) @(posedge clk_i);
    for (int k = 0; k < 8; k++) begin
      d[k] = dev_oe ? rxd_line : 1'bx;
      repeat (16) @(posedge clk_i);
    end
    check("shift frame", 32'ha5, {24'h0, d});
    rd("shift done", ADDR_CONTROL, 32'h03, 32'h02);
    give_verdict();
  end
endmodule : tb_top

bind uart_control_break_detect uart_ctl_asserts u_uart_ctl_asserts (
  .clk_i(clk_i), .nrst_i(nrst_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .rxd_i(rxd_i), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o),
  .break_reset_o(break_reset_o),
  .in_system_prog_mode_o(in_system_prog_mode_o));
`default_nettype wire
